// >>> design/gdi_gpio.v
// Contract
// - Six direction bits reset to zero; 0 means input, 1 means output.
// - Output pins drive the last written data bit.
// - Data read returns the sampled level for input pins.
// - Data read returns the stored value for output pins.
// - Six status bits reset to zero; writing 1 clears, 0 does nothing.
// - Six per-pin enable bits reset to zero gate status into summary.
// - Status bits set on their condition regardless of enables.
// - Enabled status bits are ORed into the chip GPIO event bit.
// - Interrupt pin asserts only with GPIO event and top enable set.
// - Interrupt levels must persist beyond 40 ns to be recognised; the code acts on one 100 ns sample, so levels under 100 ns can be missed.
// - Trigger condition comes from the separate configuration register.
// - Polarity 0 triggers on low level, 1 triggers on high level.
// - Open-drain outputs drive low for 0 and float for 1.
// - GPIO event appears read-only as bit 12 of chip status.
//
// Added by the designer: register access over AXI4-Lite.
`include "gdi_defines.vh"
module gdi_gpio
#(
    parameter NPINS = 6
)
(
    input wire clk,
    input wire reset_n,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NPINS-1:0] gpio_in,
    output reg [NPINS-1:0] gpio_out,
    output reg [NPINS-1:0] gpio_oe,
    output reg irq_q
);
    // Cycles a level must be held; a longest-style bound rounded so 40 ns gives one cycle.
    localparam LEVEL_CYC_RAW = `GDI_LEVEL_NS / `GDI_CLK_NS;
    localparam LEVEL_CYC = (LEVEL_CYC_RAW < 1) ? 1 : LEVEL_CYC_RAW;

    reg [NPINS-1:0] pin_direction_bits_q;
    reg [NPINS-1:0] pin_data_bits_q;
    reg [NPINS-1:0] pin_trigger_polarity_q;
    reg [NPINS-1:0] pin_buffer_type_q;
    reg [NPINS-1:0] int_status_q;
    reg [NPINS-1:0] int_enable_q;
    reg chip_gpio_en_q;
    reg [1:0] sync_fill_q;
    reg [NPINS-1:0] hit_q;
    reg [NPINS-1:0] hit_d;
    wire [NPINS-1:0] pin_sync;
    wire [NPINS-1:0] trig_level;
    wire gpio_event;
    reg [11:0] awaddr_q;
    reg aw_have_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_have_q;
    wire do_write;
    wire do_read;
    reg [31:0] rdata_d;
    reg rresp_bad_d;
    reg wr_bad_d;
    reg [NPINS-1:0] clr_d;
    integer i;

    // Every pin is resynchronised before readback or level detection.
    genvar g;
    generate
        for (g = 0; g < NPINS; g = g + 1)
        begin : g_sync
            gdi_sync u_sync
            (
                .clk(clk),
                .reset_n(reset_n),
                .d(gpio_in[g]),
                .q(pin_sync[g])
            );
        end
    endgenerate

    // Active level per pin from the polarity field of the configuration register.
    assign trig_level = ~(pin_sync ^ pin_trigger_polarity_q);

    // The level must be seen in one sample, or in two consecutive ones if LEVEL_CYC exceeds 1; one 100 ns sample
    // already exceeds 40 ns, so a glitch shorter than a sample can be missed.
    // The synchronisers come out of reset at zero, which looks like a low level.
    // Without this gate a low-trigger pin would set its status right after reset.
    always @*
    begin
        hit_d = trig_level & {NPINS{sync_fill_q[1]}};
        if (LEVEL_CYC > 1)
        begin
            hit_d = trig_level & hit_q & {NPINS{sync_fill_q[1]}};
        end
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hit_q <= `GDI_RST6;
            sync_fill_q <= 2'b00;
        end
        else
        begin
            hit_q <= trig_level;
            sync_fill_q <= {sync_fill_q[0], 1'b1};
        end
    end

    // Summary event: status bits gated by their per-pin enables.
    assign gpio_event = |(int_status_q & int_enable_q);

    // Handshake: a write fires once both address and data are held.
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    // Write channel capture; address and data may arrive in either order.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GDI_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_bad_d ? `GDI_RESP_SLVERR : `GDI_RESP_OKAY;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Unmapped addresses answer with an error and change nothing.
    always @*
    begin
        wr_bad_d = 1'b1;
        if (awaddr_q == `GDI_ADDR_CFG)
        begin
            wr_bad_d = 1'b0;
        end
        else if (awaddr_q == `GDI_ADDR_DATA_DIR)
        begin
            wr_bad_d = 1'b0;
        end
        else if (awaddr_q == `GDI_ADDR_STS_EN)
        begin
            wr_bad_d = 1'b0;
        end
        else if (awaddr_q == `GDI_ADDR_CHIP_STS)
        begin
            wr_bad_d = 1'b0;
        end
        else if (awaddr_q == `GDI_ADDR_CHIP_EN)
        begin
            wr_bad_d = 1'b0;
        end
    end

    // Status clear mask from a write of ones to the low status field.
    always @*
    begin
        clr_d = `GDI_RST6;
        if (do_write && (awaddr_q == `GDI_ADDR_STS_EN) && wstrb_q[0])
        begin
            clr_d = wdata_q[`GDI_LO_LSB +: NPINS];
        end
    end

    // Configuration, data, direction and enable registers.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_direction_bits_q <= `GDI_RST6;
            pin_data_bits_q <= `GDI_RST6;
            pin_trigger_polarity_q <= `GDI_RST6;
            pin_buffer_type_q <= `GDI_RST6;
            int_enable_q <= `GDI_RST6;
            chip_gpio_en_q <= 1'b0;
        end
        else if (do_write)
        begin
            if (awaddr_q == `GDI_ADDR_CFG)
            begin
                if (wstrb_q[0])
                    pin_buffer_type_q <= wdata_q[`GDI_LO_LSB +: NPINS];
                if (wstrb_q[2])
                    pin_trigger_polarity_q <= wdata_q[`GDI_HI_LSB +: NPINS];
            end
            else if (awaddr_q == `GDI_ADDR_DATA_DIR)
            begin
                if (wstrb_q[0])
                    pin_data_bits_q <= wdata_q[`GDI_LO_LSB +: NPINS];
                if (wstrb_q[2])
                    pin_direction_bits_q <= wdata_q[`GDI_HI_LSB +: NPINS];
            end
            else if (awaddr_q == `GDI_ADDR_STS_EN)
            begin
                if (wstrb_q[2])
                    int_enable_q <= wdata_q[`GDI_HI_LSB +: NPINS];
            end
            else if (awaddr_q == `GDI_ADDR_CHIP_EN)
            begin
                if (wstrb_q[1])
                    chip_gpio_en_q <= wdata_q[`GDI_CHIP_GPIO_BIT];
            end
        end
    end

    // Status bits: a present level wins over a same-cycle clear, so no event
    // is lost; a level that is still active simply sets the bit again.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            int_status_q <= `GDI_RST6;
        end
        else
        begin
            int_status_q <= (int_status_q & ~clr_d) | hit_d;
        end
    end

    // Pin drivers; open-drain releases the pin for a one.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gpio_out <= `GDI_RST6;
            gpio_oe <= `GDI_RST6;
        end
        else
        begin
            for (i = 0; i < NPINS; i = i + 1)
            begin
                if (pin_buffer_type_q[i])
                begin
                    gpio_out[i] <= pin_data_bits_q[i];
                    gpio_oe[i] <= pin_direction_bits_q[i];
                end
                else
                begin
                    gpio_out[i] <= 1'b0;
                    gpio_oe[i] <= pin_direction_bits_q[i] & ~pin_data_bits_q[i];
                end
            end
        end
    end

    // Interrupt output: summary event gated by the chip-level enable.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= gpio_event & chip_gpio_en_q;
        end
    end

    // Read data mux.
    always @*
    begin
        rdata_d = 32'h0000_0000;
        rresp_bad_d = 1'b0;
        if (s_axi_araddr == `GDI_ADDR_CFG)
        begin
            rdata_d[`GDI_LO_LSB +: NPINS] = pin_buffer_type_q;
            rdata_d[`GDI_HI_LSB +: NPINS] = pin_trigger_polarity_q;
        end
        else if (s_axi_araddr == `GDI_ADDR_DATA_DIR)
        begin
            rdata_d[`GDI_LO_LSB +: NPINS] = (pin_direction_bits_q & pin_data_bits_q)
                | (~pin_direction_bits_q & pin_sync);
            rdata_d[`GDI_HI_LSB +: NPINS] = pin_direction_bits_q;
        end
        else if (s_axi_araddr == `GDI_ADDR_STS_EN)
        begin
            rdata_d[`GDI_LO_LSB +: NPINS] = int_status_q;
            rdata_d[`GDI_HI_LSB +: NPINS] = int_enable_q;
        end
        else if (s_axi_araddr == `GDI_ADDR_CHIP_STS)
        begin
            rdata_d[`GDI_CHIP_GPIO_BIT] = gpio_event;
        end
        else if (s_axi_araddr == `GDI_ADDR_CHIP_EN)
        begin
            rdata_d[`GDI_CHIP_GPIO_BIT] = chip_gpio_en_q;
        end
        else
        begin
            rresp_bad_d = 1'b1;
        end
    end

    // Read channel: one read in flight, answered the cycle after acceptance.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GDI_RESP_OKAY;
        end
        else
        begin
            if (do_read)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rresp_bad_d ? `GDI_RESP_SLVERR : `GDI_RESP_OKAY;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // gdi_gpio

// >>> design/gdi_sync.v
// Two-flop synchroniser for one pin; only the second stage is read outside.
module gdi_sync
(
    input wire clk,
    input wire reset_n,
    input wire d,
    output reg q
);
    reg meta_q;

    // First stage feeds only the second stage.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // gdi_sync

// >>> include/gdi_defines.vh
`ifndef GDI_DEFINES_VH
`define GDI_DEFINES_VH
// Register byte addresses.
`define GDI_ADDR_CFG 12'h1e0
`define GDI_ADDR_DATA_DIR 12'h1e4
`define GDI_ADDR_STS_EN 12'h1e8
`define GDI_ADDR_CHIP_STS 12'h058
`define GDI_ADDR_CHIP_EN 12'h05c
// Field positions.
`define GDI_LO_LSB 0
`define GDI_HI_LSB 16
`define GDI_CHIP_GPIO_BIT 12
// Reset values.
`define GDI_RST6 6'h00
// AXI responses.
`define GDI_RESP_OKAY 2'b00
`define GDI_RESP_SLVERR 2'b10
// Least level time for a pin interrupt, in ns, and the clock period in ns.
`define GDI_LEVEL_NS 40
`define GDI_CLK_NS 100
`endif

// >>> testbench/gdi_checker_sva.sv
`include "gdi_defines.vh"
module gdi_checker
#(
    parameter NPINS = 6
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [NPINS-1:0] gpio_out,
    input wire logic [NPINS-1:0] gpio_oe,
    input wire logic irq_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wr_age_q;
    // Age of the last write beat; pin outputs may only move, and the interrupt only fall, while it is young.
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            wr_age_q <= 2'd3;
        else if ((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready))
            wr_age_q <= 2'd0;
        else if (wr_age_q != 2'd3)
            wr_age_q <= wr_age_q + 2'd1;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Pin outputs change, and the interrupt falls, only just after a write.
    oe_after_write_a: assert property (!$stable(gpio_oe) |-> wr_age_q != 2'd3)
        else $error("pin enable moved without a write");
    out_after_write_a: assert property (!$stable(gpio_out) |-> wr_age_q != 2'd3)
        else $error("pin drive moved without a write");
    irq_fall_write_a: assert property ($fell(irq_q) |-> wr_age_q != 2'd3)
        else $error("interrupt dropped without a write");
    // Bus answers and blocking.
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `GDI_RESP_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    cover property ($rose(irq_q));
    cover property ($fell(irq_q));
    cover property (s_axi_rvalid && s_axi_rresp == `GDI_RESP_SLVERR);
endmodule // gdi_checker
bind gdi_gpio gdi_checker #(.NPINS(NPINS)) u_chk (.*);

// >>> testbench/gdi_gpio_tb.sv
`include "gdi_defines.vh"
module gdi_gpio_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, irq_q;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, wr_strb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] gpio_in, gpio_out, gpio_oe, ext_lvl;
    int error_cnt, checks_done;
    gdi_gpio dut (.*);
    gdi_pins u_pins (.*);
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= wr_strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b0;
    endtask
    // Readback: stored value on outputs, pin level on inputs.
    function automatic logic [31:0] exp_dd(logic [5:0] dir, logic [5:0] v, logic [5:0] e);
        return {10'h0, dir, 10'h0, (dir & v) | (~dir & e)};
    endfunction
    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cut a hang short well after the tests should have ended.
    initial
    begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial
    begin
        logic [31:0] d;
        logic [5:0] dir, v, e, b, p;
        int i;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        error_cnt = 0;
        wr_strb = 4'hf;
        checks_done = 0;
        reset_n = 1'b0;
        ext_lvl = 6'h3f;
        d = $urandom(77);
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        // Let the pin synchronisers fill before the first readback.
        repeat (2) @(posedge clk);
        rd(`GDI_ADDR_DATA_DIR, `GDI_RESP_OKAY, d);
        chk("dd_rst", exp_dd(6'h00, 6'h00, 6'h3f), d);
        rd(`GDI_ADDR_STS_EN, `GDI_RESP_OKAY, d);
        chk("en_rst", 32'h0, d & 32'h003f0000);
        // An unmapped place refuses both ways.
        wr(12'h100, 32'hffffffff, `GDI_RESP_SLVERR);
        rd(12'h100, `GDI_RESP_SLVERR, d);
        chk("unmapped", 32'h0, d);
        // Random direction, data, buffer type and board levels.
        repeat (8)
        begin
            {dir, v, e, b} = 24'($urandom);
            wr(`GDI_ADDR_CFG, {26'h0, b}, `GDI_RESP_OKAY);
            ext_lvl <= e;
            wr(`GDI_ADDR_DATA_DIR, {10'h0, dir, 10'h0, v}, `GDI_RESP_OKAY);
            repeat (3) @(posedge clk);
            rd(`GDI_ADDR_DATA_DIR, `GDI_RESP_OKAY, d);
            chk("data_dir", exp_dd(dir, v, e), d);
            chk("oe", {26'h0, dir & (b | ~v)}, gpio_oe);
            chk("out", {26'h0, dir & b & v}, gpio_out & gpio_oe);
        end
        // Lane 0 alone writes the data field and leaves the direction field as it was.
        wr_strb = 4'h1;
        wr(`GDI_ADDR_DATA_DIR, 32'h003f003f, `GDI_RESP_OKAY);
        wr_strb = 4'hf;
        rd(`GDI_ADDR_DATA_DIR, `GDI_RESP_OKAY, d);
        chk("strb_lane", exp_dd(dir, 6'h3f, e), d);
        // One pin pulses its trigger level for a single cycle.
        p = 6'($urandom);
        i = $urandom_range(5, 0);
        wr(`GDI_ADDR_CFG, {10'h0, p, 16'h0}, `GDI_RESP_OKAY);
        wr(`GDI_ADDR_DATA_DIR, 32'h0, `GDI_RESP_OKAY);
        ext_lvl <= ~p;
        wr(`GDI_ADDR_CHIP_EN, 32'h1000, `GDI_RESP_OKAY);
        repeat (4) @(posedge clk);
        wr(`GDI_ADDR_STS_EN, 32'h3f, `GDI_RESP_OKAY);
        rd(`GDI_ADDR_STS_EN, `GDI_RESP_OKAY, d);
        chk("sts_clr", 32'h0, d);
        ext_lvl[i] <= p[i];
        @(posedge clk);
        ext_lvl[i] <= ~p[i];
        repeat (4) @(posedge clk);
        rd(`GDI_ADDR_STS_EN, `GDI_RESP_OKAY, d);
        chk("sts_set", 32'h1 << i, d);
        chk("irq_masked", 32'h0, irq_q);
        rd(`GDI_ADDR_CHIP_STS, `GDI_RESP_OKAY, d);
        chk("chip_off", 32'h0, d & 32'h1000);
        wr(`GDI_ADDR_STS_EN, 32'h10000 << i, `GDI_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("irq_on", 32'h1, irq_q);
        rd(`GDI_ADDR_STS_EN, `GDI_RESP_OKAY, d);
        chk("sts_keep", 32'h10001 << i, d);
        wr(`GDI_ADDR_CHIP_STS, 32'h0, `GDI_RESP_OKAY);
        rd(`GDI_ADDR_CHIP_STS, `GDI_RESP_OKAY, d);
        chk("chip_on", 32'h1000, d & 32'h1000);
        wr(`GDI_ADDR_CHIP_EN, 32'h0, `GDI_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("irq_gate", 32'h0, irq_q);
        wr(`GDI_ADDR_CHIP_EN, 32'h1000, `GDI_RESP_OKAY);
        wr(`GDI_ADDR_STS_EN, 32'h10001 << i, `GDI_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("irq_clr", 32'h0, irq_q);
        summarize();
    end
endmodule // gdi_gpio_tb

// >>> testbench/gdi_pins.sv
module gdi_pins
(
    input wire logic [5:0] gpio_out,
    input wire logic [5:0] gpio_oe,
    input wire logic [5:0] ext_lvl,
    output logic [5:0] gpio_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Board level: the device drive wins where enabled, else the board's level.
    // Board levels change only on clock edges, so each lasts well over 40 ns.
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);
endmodule // gdi_pins
